/* src/tmc_pkg.sv */
package tmc_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_SUPPLY = 8'h08;

	// ctrl field positions
	localparam int CTRL_TX_MODE_SEL = 0;
	localparam int CTRL_STB_N_SEL   = 1;
	localparam int CTRL_BAT_OK      = 2;
	localparam int CTRL_CORE_OK     = 3;
	localparam int CTRL_IO_OK       = 4;
	localparam int CTRL_BAT_POD     = 5;
	localparam int CTRL_CLR_WAKE    = 6;
	localparam int CTRL_CLR_POR     = 7;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int SLEEP_TIME_NS = 50000;
	localparam int SLEEP_CYC     = SLEEP_TIME_NS / CLK_PERIOD_NS;
	localparam int PON_TIME_NS   = 20000;
	localparam int PON_CYC       = PON_TIME_NS / CLK_PERIOD_NS;
	localparam int SILENCE_NS    = 1000000;
	localparam int SILENCE_CYC   = SILENCE_NS / CLK_PERIOD_NS;
	localparam int UV_LONG_NS    = 200000;
	localparam int UV_LONG_CYC   = UV_LONG_NS / CLK_PERIOD_NS;
	localparam int BIAS_NS       = 200;
	localparam int BIAS_CYC      = BIAS_NS / CLK_PERIOD_NS;
	localparam int FILTER_NS     = 1000;
	localparam int FILTER_CYC    = FILTER_NS / CLK_PERIOD_NS;
	localparam int WAKE_NS       = 1000000;
	localparam int WAKE_CYC      = WAKE_NS / CLK_PERIOD_NS;
	localparam int CNT_W         = 24;

	typedef enum logic [2:0] {
		TMC_POR, TMC_STANDBY, TMC_GOTOSLEEP, TMC_SLEEP,
		TMC_NORMAL, TMC_RXONLY
	} tmc_mode_t;

	typedef struct packed {
		logic tx_mode_select;
		logic standby_not_select;
	} tmc_sel_t;

	typedef struct packed {
		logic bat_ok;
		logic core_ok;
		logic io_ok;
		logic bat_pod;
	} tmc_supply_t;

endpackage

/* src/tmc_ctrl.sv */
// Operation
// - tx disabled in standby, go-to-sleep, sleep
// - after reset rx and error outputs high
// - standby after supply valid for settle time
// - mode pins act only with io supply valid
// - wake in sleep/go-to-sleep goes standby
// - normal/rx-only to standby on both low
// - stb low, tx high enters go-to-sleep
// - go-to-sleep sleeps after timer if clean
// - host reaches sleep only through go-to-sleep
// - tx low early in go-to-sleep: standby, rx-only if stb high
// - late tx low sleeps; bus level ignored
// - regulator on while timer, wake, or por
// - sleep: regulator off, wake receivers on
// - long undervoltage plus idle bus sleeps
// - sleep stb rising edge: normal or rx-only
// - sleep held while stb low; wake exits
// - sleep: only io undervoltage detection on
// - standby: fail-safes and local errors off
// - por on bat and core down; outputs hi-z
// - leaving por sets por flag
// - idle bus biased to ground; wake restores
// - biasing depends on mode, idle timer and wake restore
// - mode pin encoding
// - wake indication on rx and error outputs
// - wake pattern dom, rec, dom in window
`timescale 1ns/1ps
module tmc_ctrl (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// bus and local wake side
	input  wire logic        bus_dominant,
	input  wire logic        local_wake_event,
	input  wire logic        txd,
	// pins and indicators
	output logic             tx_drive,
	output logic             rxd_out,
	output logic             rxd_oe,
	output logic             error_indicator_out,
	output logic             error_oe,
	output logic             regulator_control_out,
	output logic             regulator_oe,
	output logic             bias_mid,
	output logic             bias_oe,
	output logic             failsafe_enable,
	output logic             uv_bat_core_enable
);

	// ****************************************
	// registers and state
	// ****************************************
	logic [31:0]        ctrl;
	tmc_pkg::tmc_mode_t mode;
	tmc_pkg::tmc_mode_t next_mode;
	logic [tmc_pkg::CNT_W-1:0] t_sleep, power_on_settle_time, t_idle, t_uv, t_bias;
	logic [tmc_pkg::CNT_W-1:0] t_wup;
	logic [1:0]  wup_phase;
	logic        wup_flag, lwu_flag, por_flag, stb_prev, bus_prev;
	logic        dp_wr;
	logic [7:0]  dp_addr;
	// bus idle timer value that reads as silent
	localparam logic [tmc_pkg::CNT_W-1:0] IDLE_FULL =
		tmc_pkg::CNT_W'(tmc_pkg::SILENCE_CYC);

	tmc_pkg::tmc_sel_t    sel;
	tmc_pkg::tmc_supply_t sup;
	assign sel.tx_mode_select     = ctrl[tmc_pkg::CTRL_TX_MODE_SEL];
	assign sel.standby_not_select = ctrl[tmc_pkg::CTRL_STB_N_SEL];
	assign sup.bat_ok  = ctrl[tmc_pkg::CTRL_BAT_OK];
	assign sup.core_ok = ctrl[tmc_pkg::CTRL_CORE_OK];
	assign sup.io_ok   = ctrl[tmc_pkg::CTRL_IO_OK];
	assign sup.bat_pod = ctrl[tmc_pkg::CTRL_BAT_POD];

	// ****************************************
	// bus decode
	// ****************************************
	wire take    = hsel & hready & htrans[1];
	wire wr_ctrl = dp_wr & (dp_addr == tmc_pkg::ADDR_CTRL);
	wire [31:0] status_word = {24'h00_0000, wup_phase, por_flag,
		lwu_flag, wup_flag, mode};
	wire [31:0] supply_word = {28'h000_0000, sup};
	// a write landing now is seen by the read behind it
	wire [31:0] ctrl_view = wr_ctrl ? hwdata : ctrl;
	wire [31:0] rd_word;
	assign rd_word = (haddr == tmc_pkg::ADDR_CTRL)   ? ctrl_view :
	                 (haddr == tmc_pkg::ADDR_STATUS) ? status_word :
	                 (haddr == tmc_pkg::ADDR_SUPPLY) ? supply_word :
	                 32'h0000_0000;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dp_wr <= 1'b0;
			dp_addr <= 8'h00;
		end else begin
			dp_wr <= take & hwrite;
			dp_addr <= take ? haddr : dp_addr;
		end
	end

	// clear bits are self-clearing strobes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			ctrl <= tmc_pkg::CTRL_RESET;
		else if (wr_ctrl)
			ctrl <= hwdata;
		else begin
			ctrl[tmc_pkg::CTRL_CLR_WAKE] <= 1'b0;
			ctrl[tmc_pkg::CTRL_CLR_POR]  <= 1'b0;
		end
	end

	// zero wait states, response always okay
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			// read data stands through the data phase
			if (take && !hwrite)
				hrdata <= rd_word;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ****************************************
	// supervision
	// ****************************************
	wire por_cond  = ~sup.bat_pod & ~sup.core_ok;
	wire main_ok   = sup.bat_ok | sup.core_ok;
	wire pins_live = sup.io_ok & main_ok;
	wire uv_active = (~sup.io_ok) | ((mode != tmc_pkg::TMC_SLEEP) &
		~sup.core_ok);
	wire uv_long   = (t_uv >= tmc_pkg::CNT_W'(tmc_pkg::UV_LONG_CYC));
	wire silent    = (t_idle >= tmc_pkg::CNT_W'(tmc_pkg::SILENCE_CYC));
	wire sleep_exp = (t_sleep >= tmc_pkg::CNT_W'(tmc_pkg::SLEEP_CYC));
	wire wake_pend = wup_flag | lwu_flag;
	wire low_power = (mode == tmc_pkg::TMC_STANDBY) |
		(mode == tmc_pkg::TMC_GOTOSLEEP) | (mode == tmc_pkg::TMC_SLEEP);
	wire stb_rise  = sel.standby_not_select & ~stb_prev;
	wire cmd_gts   = sel.tx_mode_select & ~sel.standby_not_select;
	wire cmd_stb   = ~sel.tx_mode_select & ~sel.standby_not_select;
	wire lwu_live  = low_power & sup.bat_ok;

	// ****************************************
	// wake pattern detector
	// ****************************************
	wire flt_ok = (t_wup >= tmc_pkg::CNT_W'(tmc_pkg::FILTER_CYC));
	wire wup_to = (t_bias >= tmc_pkg::CNT_W'(tmc_pkg::WAKE_CYC));
	wire wup_done = (wup_phase == 2'd3) & bus_dominant & flt_ok;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_prev <= 1'b0;
			t_wup <= '0;
		end else begin
			bus_prev <= bus_dominant;
			t_wup <= (bus_prev != bus_dominant) ? '0 : t_wup + 1'b1;
		end
	end

	// phase 1 dom, 2 rec, 3 second dom; dom needs past filter
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			wup_phase <= 2'd0;
		else if (!low_power || wup_to || wup_done)
			wup_phase <= 2'd0;
		else if (wup_phase == 2'd0 && bus_dominant)
			wup_phase <= 2'd1;
		else if (bus_prev != bus_dominant) begin
			if (wup_phase == 2'd1 && !bus_dominant)
				wup_phase <= (t_wup >= tmc_pkg::CNT_W'(tmc_pkg::FILTER_CYC))
					? 2'd2 : 2'd0;
			else if (wup_phase == 2'd2 && bus_dominant)
				wup_phase <= (t_wup >= tmc_pkg::CNT_W'(tmc_pkg::FILTER_CYC))
					? 2'd3 : 2'd1;
		end
	end

	// window counter and bias restore counter share t_bias
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			t_bias <= '0;
		else if (wup_phase == 2'd0)
			t_bias <= '0;
		else
			t_bias <= t_bias + 1'b1;
	end

	// ****************************************
	// wake flags, set wins over clear
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wup_flag <= 1'b0;
			lwu_flag <= 1'b0;
		end else begin
			if (wup_done)
				wup_flag <= 1'b1;
			else if (ctrl[tmc_pkg::CTRL_CLR_WAKE] || !low_power)
				wup_flag <= 1'b0;
			if (local_wake_event && lwu_live)
				lwu_flag <= 1'b1;
			else if (ctrl[tmc_pkg::CTRL_CLR_WAKE] || !low_power)
				lwu_flag <= 1'b0;
		end
	end

	// ****************************************
	// timers
	// ****************************************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			t_sleep <= '0;
			power_on_settle_time <= '0;
			t_idle <= IDLE_FULL;
			t_uv <= '0;
			stb_prev <= 1'b0;
		end else begin
			stb_prev <= pins_live ? sel.standby_not_select : stb_prev;
			t_sleep <= (mode != tmc_pkg::TMC_GOTOSLEEP) ? '0 :
				sleep_exp ? t_sleep : t_sleep + 1'b1;
			power_on_settle_time <= (mode != tmc_pkg::TMC_POR || !main_ok) ? '0 :
				power_on_settle_time + 1'b1;
			// power-up starts with the bus taken as silent
			if (mode == tmc_pkg::TMC_POR)
				t_idle <= IDLE_FULL;
			// activity: wake pattern in low power, dominant otherwise
			else if ((low_power && wup_done) ||
			    (!low_power && bus_dominant && flt_ok))
				t_idle <= '0;
			else if (!silent)
				t_idle <= t_idle + 1'b1;
			t_uv <= (!uv_active || !sup.bat_ok) ? '0 :
				uv_long ? t_uv : t_uv + 1'b1;
		end
	end

	// ****************************************
	// mode state machine
	// ****************************************
	always_comb begin
		next_mode = mode;
		case (mode)
			tmc_pkg::TMC_POR: begin
				if (main_ok && power_on_settle_time >= tmc_pkg::CNT_W'(tmc_pkg::PON_CYC))
					next_mode = tmc_pkg::TMC_STANDBY;
			end
			tmc_pkg::TMC_NORMAL, tmc_pkg::TMC_RXONLY: begin
				if (pins_live && cmd_stb)
					next_mode = tmc_pkg::TMC_STANDBY;
				else if (pins_live && cmd_gts)
					next_mode = tmc_pkg::TMC_GOTOSLEEP;
				else if (pins_live && sel.tx_mode_select)
					next_mode = tmc_pkg::TMC_NORMAL;
				else if (pins_live)
					next_mode = tmc_pkg::TMC_RXONLY;
			end
			tmc_pkg::TMC_STANDBY: begin
				if (pins_live && cmd_gts)
					next_mode = tmc_pkg::TMC_GOTOSLEEP;
				else if (pins_live && sel.standby_not_select)
					next_mode = sel.tx_mode_select ? tmc_pkg::TMC_NORMAL
						: tmc_pkg::TMC_RXONLY;
			end
			tmc_pkg::TMC_GOTOSLEEP: begin
				if (wake_pend)
					next_mode = tmc_pkg::TMC_STANDBY;
				else if (sleep_exp && !por_flag)
					next_mode = tmc_pkg::TMC_SLEEP;
				else if (pins_live && !sel.tx_mode_select && !sleep_exp)
					next_mode = sel.standby_not_select ?
						tmc_pkg::TMC_RXONLY : tmc_pkg::TMC_STANDBY;
			end
			tmc_pkg::TMC_SLEEP: begin
				if (wake_pend)
					next_mode = tmc_pkg::TMC_STANDBY;
				else if (pins_live && stb_rise)
					next_mode = sel.tx_mode_select ? tmc_pkg::TMC_NORMAL
						: tmc_pkg::TMC_RXONLY;
			end
			default: next_mode = tmc_pkg::TMC_POR;
		endcase
		if (mode != tmc_pkg::TMC_POR && mode != tmc_pkg::TMC_SLEEP &&
		    uv_long && silent)
			next_mode = tmc_pkg::TMC_SLEEP;
		if (por_cond)
			next_mode = tmc_pkg::TMC_POR;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			mode <= tmc_pkg::TMC_POR;
		else
			mode <= next_mode;
	end

	// por flag: set on leaving por mode, cleared by software
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			por_flag <= 1'b0;
		else if (mode == tmc_pkg::TMC_POR &&
		         next_mode == tmc_pkg::TMC_STANDBY)
			por_flag <= 1'b1;
		else if (ctrl[tmc_pkg::CTRL_CLR_POR])
			por_flag <= 1'b0;
	end

	// ****************************************
	// outputs
	// ****************************************
	wire in_por  = (next_mode == tmc_pkg::TMC_POR);
	wire tx_on   = (next_mode == tmc_pkg::TMC_NORMAL);
	wire reg_on  = in_por ? (sup.bat_pod | sup.core_ok) :
		(next_mode == tmc_pkg::TMC_SLEEP) ? 1'b0 :
		(next_mode == tmc_pkg::TMC_GOTOSLEEP) ?
		(~sleep_exp | wake_pend | por_flag) : 1'b1;
	wire np_low  = (next_mode == tmc_pkg::TMC_STANDBY) |
		(next_mode == tmc_pkg::TMC_GOTOSLEEP) |
		(next_mode == tmc_pkg::TMC_SLEEP);
	wire ind_rx  = np_low ? ~wake_pend : ~bus_dominant;
	wire ind_err = np_low ? ~wup_flag : sup.core_ok;
	wire ind_oe  = ~in_por & sup.io_ok;
	wire restored = (t_idle == '0) &
		(t_bias >= tmc_pkg::CNT_W'(tmc_pkg::BIAS_CYC) | wup_flag);
	wire mid     = ~in_por &
		(~np_low | ~silent | restored);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_drive <= 1'b1;
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
			error_indicator_out <= 1'b1;
			error_oe <= 1'b0;
			regulator_control_out <= 1'b0;
			regulator_oe <= 1'b0;
			bias_mid <= 1'b0;
			bias_oe <= 1'b0;
			failsafe_enable <= 1'b0;
			uv_bat_core_enable <= 1'b0;
		end else begin
			// recessive unless normal mode and txd low
			tx_drive <= ~(tx_on & pins_live & ~txd);
			rxd_out <= ind_rx;
			rxd_oe <= ind_oe;
			error_indicator_out <= ind_err;
			error_oe <= ind_oe;
			regulator_control_out <= reg_on;
			regulator_oe <= reg_on;
			bias_mid <= mid;
			bias_oe <= ~in_por;
			failsafe_enable <= tx_on;
			uv_bat_core_enable <= ~in_por &
				(next_mode != tmc_pkg::TMC_SLEEP);
		end
	end

endmodule

/* testbench/tmc_ctrl_assertions.sv */
`timescale 1ns/1ps
module tmc_ctrl_checker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// pins
	input wire logic txd,
	input wire logic tx_drive,
	input wire logic rxd_oe,
	input wire logic error_oe,
	input wire logic regulator_control_out,
	input wire logic regulator_oe,
	input wire logic failsafe_enable,
	input wire logic uv_bat_core_enable
);
	// ****************
	// pin relations
	// ****************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_txd_ignored: assert property (txd |=> tx_drive)
		else $error("transmitter driven while txd high");
	a_tx_normal: assert property (!tx_drive |-> failsafe_enable)
		else $error("transmitter active outside normal mode");
	a_normal_pins: assert property (
		failsafe_enable |-> rxd_oe && error_oe && regulator_oe)
		else $error("normal mode with pins released");
	a_reg_pair: assert property (
		regulator_oe == regulator_control_out)
		else $error("regulator level and enable disagree");
	a_sleep_quiet: assert property (
		!regulator_oe |-> !uv_bat_core_enable && !failsafe_enable)
		else $error("supervision left on in sleep");
	a_por_quiet: assert property (
		$rose(rst_n) |-> tx_drive && !rxd_oe && !error_oe)
		else $error("outputs driven while leaving reset");
	a_oe_pair: assert property (rxd_oe == error_oe)
		else $error("rx and error enables disagree");
	a_sleep_path: assert property (
		$fell(regulator_oe) |-> !$past(failsafe_enable))
		else $error("sleep entered straight from normal");
endmodule

/* testbench/tmc_bus_model.sv */
`timescale 1ns/1ps
module tmc_bus_model #(
	parameter int PHASE = tmc_pkg::FILTER_CYC + 50
) (
	// clock and command
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic start_wup,
	// bus level, high when dominant
	output logic     bus_dominant
);
	int left;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			left <= 0;
		else if (start_wup && left == 0)
			left <= 3 * PHASE;
		else if (left > 0)
			left <= left - 1;
	end
	// dominant, recessive, dominant, then released to recessive
	assign bus_dominant = (left > 2 * PHASE)
		|| (left > 0 && left <= PHASE);
endmodule

/* testbench/tmc_ctrl_bench.sv */
`timescale 1ns/1ps
module tmc_ctrl_bench;
	// ****************
	// signals
	// ****************
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        hsel = 1'b1;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] r;
	logic        hreadyout, hresp, bus_dominant, tx_drive, rxd_out;
	logic        rxd_oe, error_indicator_out, error_oe, bias_mid;
	logic        regulator_control_out, regulator_oe, bias_oe;
	logic        failsafe_enable, uv_bat_core_enable;
	logic        lwake = 1'b0;
	logic        txd = 1'b0;
	logic        start_wup = 1'b0;
	int          err_total = 0;
	int          total_checks = 0;
	int          cyc = 0;
	// ctrl written, status and tx_drive expected
	localparam logic [14:0] ROWS [6] = '{
		{8'h3F, 6'h24, 1'b0},
		{8'h3E, 6'h25, 1'b1},
		{8'h3C, 6'h21, 1'b1},
		{8'h2F, 6'h21, 1'b1},
		{8'h3D, 6'h22, 1'b1},
		{8'h3C, 6'h21, 1'b1}
	};

	always #5 core_clk = ~core_clk;

	tmc_ctrl u_dut (
		.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.bus_dominant, .local_wake_event(lwake), .txd, .tx_drive,
		.rxd_out, .rxd_oe, .error_indicator_out, .error_oe,
		.regulator_control_out, .regulator_oe, .bias_mid, .bias_oe,
		.failsafe_enable, .uv_bat_core_enable
	);
	tmc_bus_model u_bus (.core_clk, .rst_n, .start_wup, .bus_dominant);

	// ****************
	// tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] d);
		ahb(1'b1, tmc_pkg::ADDR_CTRL, {24'h0, d});
	endtask
	task automatic wcyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic st(input logic [5:0] e);
		ahb(1'b0, tmc_pkg::ADDR_STATUS, 32'h0);
		chk({26'h0, r[5:0]}, {26'h0, e});
	endtask
	task automatic pins(input logic [5:0] e);
		chk({26'h0, rxd_oe, rxd_out, error_oe, error_indicator_out,
			regulator_oe, regulator_control_out}, {26'h0, e});
	endtask
	task automatic bias(input logic [1:0] e);
		chk({30'h0, bias_oe, bias_mid}, {30'h0, e});
	endtask
	task automatic wake_local();
		lwake <= 1'b1;
		wcyc(5);
		lwake <= 1'b0;
		wcyc(5);
	endtask
	task automatic sleep_now();
		wr(8'h3D);
		wcyc(tmc_pkg::SLEEP_CYC + 20);
		wr(8'h3C);
		wcyc(5);
		st(6'h03);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 70000) begin
			err_total++;
			summarize();
		end
	end

	// ****************
	// sequence
	// ****************
	initial begin
		wcyc(11);
		chk({31'h0, tx_drive}, 32'h1);
		pins(6'h14);
		bias(2'h0);
		wcyc(1);
		rst_n <= 1'b1;
		wcyc(1);
		$display("reset test done");
		wr(8'h3C);
		wcyc(tmc_pkg::PON_CYC - 50);
		st(6'h00);
		wcyc(100);
		st(6'h21);
		pins(6'h3F);
		bias(2'h2);
		foreach (ROWS[i]) begin
			wr(ROWS[i][14:7]);
			wcyc(3);
			st(ROWS[i][6:1]);
			chk({31'h0, tx_drive}, {31'h0, ROWS[i][0]});
			pins(ROWS[i][11] ? 6'h3F : 6'h17);
			bias(ROWS[i][3] ? 2'h3 : 2'h2);
		end
		txd <= 1'b1;
		ahb(1'b0, 8'h0C, 32'h0);
		chk(r, 32'h0);
		$display("table test done");
		wr(8'h2C);
		wcyc(tmc_pkg::UV_LONG_CYC + 20);
		st(6'h23);
		pins(6'h14);
		wr(8'h3E);
		wcyc(5);
		st(6'h25);
		$display("undervoltage test done");
		wr(8'h3D);
		wcyc(tmc_pkg::SLEEP_CYC + 20);
		st(6'h22);
		pins(6'h3F);
		wr(8'hBD);
		wcyc(5);
		st(6'h03);
		pins(6'h3C);
		chk({31'h0, uv_bat_core_enable}, 32'h0);
		wr(8'h3C);
		wcyc(5);
		st(6'h03);
		wake_local();
		st(6'h11);
		pins(6'h2F);
		wr(8'h7C);
		wcyc(5);
		st(6'h01);
		$display("local wake test done");
		sleep_now();
		bias(2'h2);
		start_wup <= 1'b1;
		wcyc(1);
		start_wup <= 1'b0;
		wcyc(200);
		wake_local();
		wcyc(400);
		st(6'h19);
		pins(6'h2B);
		bias(2'h3);
		wr(8'h7C);
		wcyc(5);
		pins(6'h3F);
		$display("bus wake test done");
		sleep_now();
		wr(8'h3F);
		wcyc(5);
		st(6'h04);
		sleep_now();
		wr(8'h3E);
		wcyc(5);
		st(6'h05);
		$display("sleep exit test done");
		wr(8'h10);
		wcyc(5);
		st(6'h00);
		pins(6'h10);
		bias(2'h0);
		wr(8'h3C);
		wcyc(tmc_pkg::PON_CYC + 50);
		st(6'h21);
		bias(2'h2);
		$display("supply test done");
		summarize();
	end
endmodule

bind tmc_ctrl tmc_ctrl_checker u_chk (
	.core_clk, .rst_n, .txd, .tx_drive, .rxd_oe, .error_oe,
	.regulator_control_out, .regulator_oe, .failsafe_enable,
	.uv_bat_core_enable
);
